/* smbus_addr_match_data_path.v */
// Two-channel two-wire serial data path: START filter, slave address match,
// acknowledge selection, MSB-first shift register and master sequencing.
// Assumes open-drain SCL/SDA resolved outside and a one-cycle register port.
// Operation
// - By default an SCL fall one clock after SDA fall is a START.
// - Filter setting adds 2, 4 or 8 clocks to that START separation.
// - Address match compares only bit positions whose mask bit is one.
// - With hardware acknowledge, general call matches when its enable is set, or when own address is zero under the mask.
// - Hardware acknowledge off: firmware acknowledges; on: device acknowledges itself.
// - Two independent channels, each with own address, mask and enables.
// - Data register holds next or last byte, stable while interrupt flag set.
// - Bytes shift out MSB first; first received bit lands in MSB.
// - While transmitting, bus bits shift in so data shows the bus byte.
// - Lost arbitration turns master transmitter into slave receiver, data kept.
// - Master read sends START then address with direction bit one.
// - Master receiver drives SCL and samples SDA; slave drives data.
// - Hardware acknowledge off: request flag and interrupt before acknowledge bit.
// - Hardware acknowledge on: device sends acknowledge, then raises interrupt.
// - Acknowledge bit one sends ACK, zero sends NACK.
// - Leave master receiver after stop request and STOP; data write selects transmit.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`include "smbus_link_defs.vh"

module smbus_addr_match_data_path #(
   parameter [15:0] SCL_HALF_CYCLES = `SCL_HALF_CYC
) (
   input wire clk_in,
   input wire rst_in,
   input wire [8:0] addr_in,
   input wire [7:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [7:0] rdata_out,
   output wire irq_out,
   input wire [1:0] scl_in,
   input wire [1:0] sda_in,
   output wire [1:0] scl_out,
   output wire [1:0] scl_oe_out,
   output wire [1:0] sda_out,
   output wire [1:0] sda_oe_out
);

localparam NUM_CH = `NUM_CHANNELS;
localparam [4:0] S_IDLE = 5'h01;
localparam [4:0] S_START = 5'h02;
localparam [4:0] S_XFER = 5'h04;
localparam [4:0] S_HOLD = 5'h08;
localparam [4:0] S_STOP = 5'h10;

wire [15:0] rd_flat;
wire [1:0] irq_ch;

// Open-drain pins only ever pull low.
assign scl_out = 2'h0;
assign sda_out = 2'h0;
assign irq_out = |irq_ch;

////////////////////////////////////////////////////////////////////////////////

// Read data is registered and stands only in the cycle after the strobe.
always @(posedge clk_in)
begin
   if (rst_in)
      rdata_out <= 8'h00;
   else if (rd_in)
      rdata_out <= addr_in[`CH_SEL_BIT] ? rd_flat[15:8] : rd_flat[7:0];
   else
      rdata_out <= 8'h00;
end

////////////////////////////////////////////////////////////////////////////////

genvar ch;
generate
for (ch = 0; ch < NUM_CH; ch = ch + 1)
begin : chan
   reg scl_m_reg, scl_s_reg, scl_d_reg, sda_m_reg, sda_s_reg, sda_d_reg;
   reg [7:0] ctrl_reg, data_reg, adm_reg, adr_reg;
   reg [3:0] stat_reg, imask_reg, fcnt_reg, bit_cnt_reg;
   reg [4:0] state_reg;
   reg [1:0] step_reg;
   reg [15:0] tmr_reg;
   reg pend_reg, master_reg, tx_reg, addr_ph_reg, ack_request_flag_reg, ackrx_reg;
   reg out_bit_reg, sda_low_reg, scl_low_reg, hold_pre_reg, wrote_reg, acked_reg;
   wire sel = (addr_in[`CH_SEL_BIT] == (ch == 1));
   wire en = ctrl_reg[`CTRL_EN];
   wire si = stat_reg[`ST_SI];
   wire hw = adm_reg[`HW_ACK_BIT];
   wire ack_bit = ctrl_reg[`CTRL_ACK];
   wire rise = scl_s_reg & ~scl_d_reg;
   wire fall = ~scl_s_reg & scl_d_reg;
   wire sda_fall_h = scl_s_reg & scl_d_reg & ~sda_s_reg & sda_d_reg;
   wire stop_det = scl_s_reg & scl_d_reg & sda_s_reg & ~sda_d_reg;
   wire [1:0] filt = ctrl_reg[`CTRL_FILT_HI:`CTRL_FILT_LO];
   wire half_done = (tmr_reg >= SCL_HALF_CYCLES);
   wire [7:0] stat_view = {ackrx_reg, tx_reg, master_reg, ack_request_flag_reg, stat_reg};
   wire [3:0] need;
   wire start_det, match, tx_next;
   reg [7:0] rd_val;

   // Required separation grows with the filter setting; default is one clock.
   assign need = (filt == 2'h0) ? `START_HOLD_BASE :
                 (filt == 2'h1) ? `START_HOLD_X2 :
                 (filt == 2'h2) ? `START_HOLD_X4 : `START_HOLD_X8;
   assign start_det = fall & pend_reg & (fcnt_reg >= need);

   // The direction bit never takes part; masked-off positions match either value.
   assign match = (((data_reg[7:1] ^ adr_reg[7:1]) & adm_reg[7:1]) == 7'h00) |
                  (adr_reg[`GC_BIT] & (data_reg[7:1] == 7'h00));

   // After an address byte the direction bit picks the role; a data write turns
   // a master receiver into a transmitter.
   assign tx_next = addr_ph_reg ? (master_reg ? ~data_reg[0] : data_reg[0]) :
                    ((master_reg & wrote_reg) | tx_reg);

   assign irq_ch[ch] = |(stat_reg & imask_reg);
   assign scl_oe_out[ch] = scl_low_reg;
   assign sda_oe_out[ch] = sda_low_reg;
   assign rd_flat[ch * 8 + 7:ch * 8] = rd_val;

   // Register read view; unmapped offsets read as zero.
   always @*
   begin
      rd_val = 8'h00;
      if (sel)
      begin
         case (addr_in[7:0])
            `OFS_CTRL: rd_val = ctrl_reg;
            `OFS_STAT: rd_val = stat_view;
            `OFS_DATA: rd_val = data_reg;
            `OFS_IMASK: rd_val = {4'h0, imask_reg};
            `OFS_MASK: rd_val = adm_reg;
            `OFS_ADDR: rd_val = adr_reg;
            default: rd_val = 8'h00;
         endcase
      end
   end

   // One process per channel holds registers, filter and engine, so that event
   // sets placed after the bus write win over a same-cycle clear.
   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         scl_m_reg <= 1'b1;
         scl_s_reg <= 1'b1;
         scl_d_reg <= 1'b1;
         sda_m_reg <= 1'b1;
         sda_s_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         ctrl_reg <= `RST_CTRL;
         data_reg <= `RST_DATA;
         adm_reg <= `RST_MASK;
         adr_reg <= `RST_ADDR;
         stat_reg <= `RST_FLAGS;
         imask_reg <= `RST_FLAGS;
         fcnt_reg <= 4'h0;
         bit_cnt_reg <= 4'h0;
         state_reg <= S_IDLE;
         step_reg <= 2'h0;
         tmr_reg <= 16'h0000;
         pend_reg <= 1'b0;
         master_reg <= 1'b0;
         tx_reg <= 1'b0;
         addr_ph_reg <= 1'b0;
         ack_request_flag_reg <= 1'b0;
         ackrx_reg <= 1'b0;
         out_bit_reg <= 1'b1;
         sda_low_reg <= 1'b0;
         scl_low_reg <= 1'b0;
         hold_pre_reg <= 1'b0;
         wrote_reg <= 1'b0;
         acked_reg <= 1'b0;
      end
      else
      begin
         scl_m_reg <= scl_in[ch];
         scl_s_reg <= scl_m_reg;
         scl_d_reg <= scl_s_reg;
         sda_m_reg <= sda_in[ch];
         sda_s_reg <= sda_m_reg;
         sda_d_reg <= sda_s_reg;
         if (wr_in & sel)
         begin
            case (addr_in[7:0])
               `OFS_CTRL: ctrl_reg <= wdata_in;
               `OFS_STAT: stat_reg <= stat_reg & ~wdata_in[3:0];
               `OFS_DATA:
               begin
                  data_reg <= wdata_in;
                  wrote_reg <= si;
               end
               `OFS_IMASK: imask_reg <= wdata_in[3:0];
               `OFS_MASK: adm_reg <= wdata_in;
               `OFS_ADDR: adr_reg <= wdata_in;
               default: ;
            endcase
         end
         // Separation counter starts at one on the SDA fall and saturates.
         if (sda_fall_h)
         begin
            pend_reg <= 1'b1;
            fcnt_reg <= 4'h1;
         end
         else if (fall | stop_det)
            pend_reg <= 1'b0;
         else if (pend_reg & (fcnt_reg != 4'hF))
            fcnt_reg <= fcnt_reg + 4'h1;
         if (start_det)
            stat_reg[`ST_START] <= 1'b1;
         if (stop_det)
            stat_reg[`ST_STOP] <= 1'b1;
         if (tmr_reg != 16'hFFFF)
            tmr_reg <= tmr_reg + 16'h0001;
         if (!en)
         begin
            state_reg <= S_IDLE;
            master_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            scl_low_reg <= 1'b0;
         end
         else
         begin
            case (state_reg)
               S_IDLE:
               begin
                  sda_low_reg <= 1'b0;
                  scl_low_reg <= 1'b0;
                  if (ctrl_reg[`CTRL_STA] & scl_s_reg & sda_s_reg & ~pend_reg)
                  begin
                     state_reg <= S_START;
                     step_reg <= 2'h0;
                     master_reg <= 1'b1;
                     tmr_reg <= 16'h0000;
                  end
               end
               // Release both lines, then SDA low, then SCL low; also serves a repeat.
               S_START:
               begin
                  case (step_reg)
                     2'h0:
                     begin
                        sda_low_reg <= 1'b0;
                        scl_low_reg <= 1'b0;
                        if (!(scl_s_reg & sda_s_reg))
                           tmr_reg <= 16'h0000;
                        else if (half_done)
                        begin
                           sda_low_reg <= 1'b1;
                           step_reg <= 2'h1;
                           tmr_reg <= 16'h0000;
                        end
                     end
                     2'h1:
                     begin
                        if (half_done)
                        begin
                           scl_low_reg <= 1'b1;
                           step_reg <= 2'h2;
                        end
                     end
                     default:
                     begin
                        if (!scl_s_reg)
                        begin
                           state_reg <= S_XFER;
                           tx_reg <= 1'b1;
                           addr_ph_reg <= 1'b1;
                           bit_cnt_reg <= 4'h0;
                           out_bit_reg <= data_reg[7];
                           sda_low_reg <= ~data_reg[7];
                           ctrl_reg[`CTRL_STA] <= 1'b0;
                           tmr_reg <= 16'h0000;
                        end
                     end
                  endcase
               end
               S_XFER:
               begin
                  // Low phase ends after a half period for both roles; only a master
                  // pulls SCL low again, and a slow SCL rise stretches the high phase.
                  if (scl_low_reg)
                  begin
                     if (half_done)
                     begin
                        scl_low_reg <= 1'b0;
                        tmr_reg <= 16'h0000;
                     end
                  end
                  else if (!scl_s_reg)
                     tmr_reg <= 16'h0000;
                  else if (master_reg & half_done)
                  begin
                     scl_low_reg <= 1'b1;
                     tmr_reg <= 16'h0000;
                  end
                  if (rise)
                  begin
                     if (bit_cnt_reg < 4'h8)
                     begin
                        data_reg <= {data_reg[6:0], sda_s_reg};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (master_reg & tx_reg & out_bit_reg & ~sda_s_reg)
                        begin
                           master_reg <= 1'b0;
                           tx_reg <= 1'b0;
                           scl_low_reg <= 1'b0;
                           sda_low_reg <= 1'b0;
                           stat_reg[`ST_ARB] <= 1'b1;
                        end
                     end
                     else
                     begin
                        if (tx_reg)
                           ackrx_reg <= ~sda_s_reg;
                        bit_cnt_reg <= 4'h9;
                     end
                  end
                  if (fall)
                  begin
                     if (bit_cnt_reg < 4'h8)
                     begin
                        out_bit_reg <= data_reg[7];
                        sda_low_reg <= tx_reg & ~data_reg[7];
                     end
                     else if (bit_cnt_reg == 4'h8)
                     begin
                        if (tx_reg)
                           sda_low_reg <= 1'b0;
                        else if (hw)
                        begin
                           if (addr_ph_reg & ~master_reg)
                           begin
                              sda_low_reg <= match;
                              acked_reg <= match;
                              if (!match)
                                 state_reg <= S_IDLE;
                           end
                           else
                           begin
                              sda_low_reg <= ack_bit;
                              acked_reg <= ack_bit;
                           end
                        end
                        else
                        begin
                           stat_reg[`ST_SI] <= 1'b1;
                           ack_request_flag_reg <= 1'b1;
                           hold_pre_reg <= 1'b1;
                           sda_low_reg <= 1'b0;
                           scl_low_reg <= 1'b1;
                           state_reg <= S_HOLD;
                        end
                     end
                     else
                     begin
                        sda_low_reg <= 1'b0;
                        if (~master_reg & ~tx_reg & addr_ph_reg & ~acked_reg)
                           state_reg <= S_IDLE;
                        else
                        begin
                           // A byte acknowledged by software has already raised its flag
                           // before the acknowledge bit, so it does not raise another here.
                           stat_reg[`ST_SI] <= tx_reg | hw;
                           hold_pre_reg <= 1'b0;
                           scl_low_reg <= 1'b1;
                           state_reg <= S_HOLD;
                        end
                     end
                  end
               end
               // SCL is held low while the flag is set, so data stays put.
               S_HOLD:
               begin
                  scl_low_reg <= 1'b1;
                  tmr_reg <= 16'h0000;
                  if (!si)
                  begin
                     state_reg <= S_XFER;
                     if (hold_pre_reg)
                     begin
                        ack_request_flag_reg <= 1'b0;
                        sda_low_reg <= ack_bit;
                        acked_reg <= ack_bit;
                     end
                     else if (master_reg & ctrl_reg[`CTRL_STO])
                     begin
                        state_reg <= S_STOP;
                        step_reg <= 2'h0;
                     end
                     else if (master_reg & ctrl_reg[`CTRL_STA])
                     begin
                        state_reg <= S_START;
                        step_reg <= 2'h0;
                     end
                     else if (~master_reg & tx_reg & ~addr_ph_reg & ~ackrx_reg)
                        state_reg <= S_IDLE;
                     else
                     begin
                        bit_cnt_reg <= 4'h0;
                        tx_reg <= tx_next;
                        addr_ph_reg <= 1'b0;
                        wrote_reg <= 1'b0;
                        out_bit_reg <= data_reg[7];
                        sda_low_reg <= tx_next & ~data_reg[7];
                     end
                  end
               end
               // SDA low, release SCL, then release SDA while SCL is high.
               S_STOP:
               begin
                  case (step_reg)
                     2'h0:
                     begin
                        sda_low_reg <= 1'b1;
                        if (half_done)
                        begin
                           scl_low_reg <= 1'b0;
                           step_reg <= 2'h1;
                           tmr_reg <= 16'h0000;
                        end
                     end
                     2'h1:
                     begin
                        if (!scl_s_reg)
                           tmr_reg <= 16'h0000;
                        else if (half_done)
                        begin
                           sda_low_reg <= 1'b0;
                           step_reg <= 2'h2;
                           tmr_reg <= 16'h0000;
                        end
                     end
                     default:
                     begin
                        if (half_done)
                        begin
                           state_reg <= S_IDLE;
                           master_reg <= 1'b0;
                           tx_reg <= 1'b0;
                           ctrl_reg[`CTRL_STO] <= 1'b0;
                        end
                     end
                  endcase
               end
               default: state_reg <= S_IDLE;
            endcase
            // Another master's START or STOP restarts or ends slave operation.
            if (start_det & ~master_reg)
            begin
               state_reg <= S_XFER;
               tx_reg <= 1'b0;
               addr_ph_reg <= 1'b1;
               bit_cnt_reg <= 4'h0;
               sda_low_reg <= 1'b0;
               scl_low_reg <= 1'b0;
            end
            else if (stop_det & ~master_reg)
            begin
               state_reg <= S_IDLE;
               sda_low_reg <= 1'b0;
               scl_low_reg <= 1'b0;
            end
         end
      end
   end
end
endgenerate

endmodule

/* smbus_link_defs.vh */
// Constants for the two-channel SMBus address-match and data-path block.
// Assumes inclusion by bare name from the design file; holds definitions only.
`ifndef SMBUS_LINK_DEFS_VH
`define SMBUS_LINK_DEFS_VH

// Number of independent interface channels; bit 8 of the address picks one.
`define NUM_CHANNELS 2
`define CH_SEL_BIT 8

// Register offsets inside one channel page.
`define OFS_CTRL 8'hC0
`define OFS_STAT 8'hC1
`define OFS_DATA 8'hC2
`define OFS_IMASK 8'hC3
`define OFS_MASK 8'hCE
`define OFS_ADDR 8'hCF

// Reset values.
`define RST_CTRL 8'h00
`define RST_DATA 8'h00
`define RST_MASK 8'hFE
`define RST_ADDR 8'h00
`define RST_FLAGS 4'h0

// Control register fields.
`define CTRL_EN 0
`define CTRL_STA 1
`define CTRL_STO 2
`define CTRL_ACK 3
`define CTRL_FILT_HI 5
`define CTRL_FILT_LO 4

// Status fields: sticky event bits 3:0, live state bits 7:4.
`define ST_SI 0
`define ST_START 1
`define ST_STOP 2
`define ST_ARB 3

// Slave address and mask fields.
`define HW_ACK_BIT 0
`define GC_BIT 0

// Least SDA-fall to SCL-fall separation for a START, in system clocks.
`define START_HOLD_BASE 4'h1
`define START_HOLD_X2 4'h3
`define START_HOLD_X4 4'h5
`define START_HOLD_X8 4'h9

// Serial clock half period generated as master.
`define CLK_PERIOD_NS 20
`define SCL_HALF_NS 5000
`define SCL_HALF_CYC (`SCL_HALF_NS / `CLK_PERIOD_NS)

`endif

/* smbus_path_monitor.sv */
// Checker for the two-channel serial data path, bound to its top module.
// Assumes the bus traffic of interest runs on channel 0.
`timescale 1ns/1ns
module smbus_path_monitor #(
   parameter [15:0] SCL_HALF_CYCLES = 16'd4
) (
   input wire clk_in,
   input wire rst_in,
   input wire [8:0] addr_in,
   input wire [7:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   input wire [7:0] rdata_out,
   input wire irq_out,
   input wire [1:0] scl_in,
   input wire [1:0] sda_in,
   input wire [1:0] scl_out,
   input wire [1:0] scl_oe_out,
   input wire [1:0] sda_out,
   input wire [1:0] sda_oe_out
);
   reg [15:0] low_cnt;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   ////////////////////////////////////////////////////////////////////////////
   // Length of the present SCL low phase driven by channel 0.
   always @(posedge clk_in)
   begin
      low_cnt <= (scl_oe_out[0] && !rst_in) ? low_cnt + 16'd1 : 16'd0;
   end
   ////////////////////////////////////////////////////////////////////////////
   property p_rdata_idle;
      !rd_in |=> rdata_out == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
   property p_reg_readback;
      wr_in && addr_in[7:0] == 8'hCF ##2 rd_in && addr_in == $past(addr_in, 2) |=> rdata_out == $past(wdata_in, 3);
   endproperty
   a_reg_readback: assert property (p_reg_readback) else $error("address register readback wrong");
   property p_after_reset;
      $fell(rst_in) |-> !irq_out && scl_oe_out == 2'b00 && sda_oe_out == 2'b00 && rdata_out == 8'h00;
   endproperty
   a_after_reset: assert property (p_after_reset) else $error("outputs active after reset");
   property p_open_drain;
      scl_out == 2'b00 && sda_out == 2'b00;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("line driven high");
   property p_irq_sticky;
      $fell(irq_out) |-> $past(wr_in);
   endproperty
   a_irq_sticky: assert property (p_irq_sticky) else $error("interrupt dropped without a write");
   property p_start_order;
      $rose(sda_oe_out[0]) && scl_in[0] && !scl_oe_out[0] |->
         sda_oe_out[0] throughout (1'b1 ##[1:600] $rose(scl_oe_out[0]));
   endproperty
   a_start_order: assert property (p_start_order) else $error("start not followed by clock low");
   property p_scl_low_min;
      $fell(scl_oe_out[0]) |-> low_cnt + 16'd1 >= SCL_HALF_CYCLES;
   endproperty
   a_scl_low_min: assert property (p_scl_low_min) else $error("clock low phase too short");
   property p_unmapped;
      rd_in && addr_in[7:0] == 8'hD0 |=> rdata_out == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

bind smbus_addr_match_data_path smbus_path_monitor #(.SCL_HALF_CYCLES(SCL_HALF_CYCLES)) mon (.clk_in(clk_in),
   .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .irq_out(irq_out), .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
   .sda_out(sda_out), .sda_oe_out(sda_oe_out));

/* bus_slave_model.sv */
// Far-side slave: acknowledges its own address and returns one byte on a read.
// Assumes resolved open-drain lines with pull-ups; the master makes SCL.
`timescale 1ns/1ns
module bus_slave_model #(
   parameter [6:0] OWN_ADDR = 7'h34,
   parameter [7:0] TX_BYTE = 8'hA5
) (
   input wire scl_in,
   input wire sda_in,
   output reg sda_oe_out,
   output reg [7:0] rx_addr_out,
   output reg ack_seen_out
);
   integer n;
   ////////////////////////////////////////////////////////////////////////////
   // SDA moves only while SCL is low, so the model never fakes a START or STOP.
   initial
   begin
      sda_oe_out = 1'b0;
      rx_addr_out = 8'h00;
      ack_seen_out = 1'b0;
      forever
      begin
         @(negedge sda_in iff scl_in === 1'b1);
         for (n = 0; n < 8; n = n + 1)
         begin
            @(posedge scl_in);
            rx_addr_out = {rx_addr_out[6:0], sda_in};
         end
         @(negedge scl_in);
         sda_oe_out = (rx_addr_out[7:1] == OWN_ADDR);
         @(negedge scl_in);
         sda_oe_out = 1'b0;
         if (rx_addr_out[7:1] == OWN_ADDR && rx_addr_out[0])
         begin
            for (n = 7; n >= 0; n = n - 1)
            begin
               sda_oe_out = ~TX_BYTE[n];
               @(negedge scl_in);
            end
            sda_oe_out = 1'b0;
            @(posedge scl_in);
            ack_seen_out = ~sda_in;
         end
      end
   end
endmodule

/* testbench.sv */
// Self-checking bench for the two-channel serial data path.
// Assumes channel 0 faces the slave model; channel 1 idles on pull-ups.
`timescale 1ns/1ns
module testbench;
   reg clk_in = 1'b0;
   reg rst_in = 1'b1;
   reg [8:0] addr_in = 9'h000;
   reg [7:0] wdata_in = 8'h00;
   reg wr_in = 1'b0;
   reg rd_in = 1'b0;
   wire [7:0] rdata_out;
   wire irq_out;
   wire [1:0] scl_out;
   wire [1:0] scl_oe_out;
   wire [1:0] sda_out;
   wire [1:0] sda_oe_out;
   wire slv_oe;
   wire [7:0] slv_addr;
   wire slv_ack;
   wire [1:0] scl_w = ~scl_oe_out;
   wire [1:0] sda_w = ~sda_oe_out & {1'b1, ~slv_oe};
   integer fail_count = 0;
   integer comparisons = 0;
   reg [7:0] v;
   ////////////////////////////////////////////////////////////////////////////
   // Half period of four clocks keeps each SCL phase clear of the synchroniser delay.
   always #10 clk_in = ~clk_in;
   smbus_addr_match_data_path #(.SCL_HALF_CYCLES(16'd4)) dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out), .scl_in(scl_w),
      .sda_in(sda_w), .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_out(sda_out), .sda_oe_out(sda_oe_out));
   bus_slave_model slave (.scl_in(scl_w[0]), .sda_in(sda_w[0]), .sda_oe_out(slv_oe), .rx_addr_out(slv_addr),
      .ack_seen_out(slv_ack));
   ////////////////////////////////////////////////////////////////////////////
   task chk(input string nm, input [7:0] e, input [7:0] g);
   begin
      comparisons = comparisons + 1;
      if (g !== e)
      begin
         fail_count = fail_count + 1;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   end
   endtask
   task wr(input [8:0] a, input [7:0] d);
   begin
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      @(posedge clk_in);
   end
   endtask
   // Read data stand only in the cycle after the strobe, so sample mid-cycle.
   task rd(input [8:0] a, output [7:0] d);
   begin
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      d = rdata_out;
      @(posedge clk_in);
   end
   endtask
   task irq_is(input e);
   begin
      @(negedge clk_in);
      chk("irq_out", {7'h00, e}, {7'h00, irq_out});
      @(posedge clk_in);
   end
   endtask
   task wait_irq;
      integer n;
   begin
      n = 0;
      @(negedge clk_in);
      while (irq_out !== 1'b1 && n < 3000)
      begin
         @(negedge clk_in);
         n = n + 1;
      end
      chk("irq wait", 8'h01, {7'h00, irq_out});
      @(posedge clk_in);
   end
   endtask
   task close_out;
   begin
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task test_regs;
   begin
      rd(9'h0CE, v);
      chk("mask reset", 8'hFE, v);
      rd(9'h0CF, v);
      chk("addr reset", 8'h00, v);
      rd(9'h0C2, v);
      chk("data reset", 8'h00, v);
      wr(9'h1CE, 8'h7F);
      wr(9'h1CF, 8'h69);
      rd(9'h1CF, v);
      chk("addr ch1", 8'h69, v);
      rd(9'h0CE, v);
      chk("mask ch0", 8'hFE, v);
      rd(9'h0D0, v);
      chk("unmapped", 8'h00, v);
      $display("test_regs done");
   end
   endtask
   // Master read of one byte; hardware or software acknowledge, then STOP.
   task master_read(input hw);
      integer n;
   begin
      wr(9'h0CE, {7'h7F, hw});
      wr(9'h0C3, 8'h01);
      wr(9'h0C2, 8'h69);
      wr(9'h0C0, hw ? 8'h0B : 8'h03);
      wait_irq;
      chk("addr sent", 8'h69, slv_addr);
      rd(9'h0C1, v);
      chk("stat addr", 8'h81, v & 8'h81);
      wr(9'h0C3, 8'h00);
      irq_is(1'b0);
      wr(9'h0C3, 8'h01);
      irq_is(1'b1);
      wr(9'h0C1, 8'h01);
      wait_irq;
      if (hw)
         chk("ack first", 8'h01, {7'h00, slv_ack});
      rd(9'h0C1, v);
      chk("ack request", {3'b000, ~hw, 4'h1}, v & 8'h11);
      rd(9'h0C2, v);
      chk("data", 8'hA5, v);
      rd(9'h0C2, v);
      chk("data stable", 8'hA5, v);
      wr(9'h0C0, 8'h05);
      wr(9'h0C1, 8'h01);
      n = 0;
      v = 8'h04;
      while (v[2] !== 1'b0 && n < 200)
      begin
         rd(9'h0C0, v);
         n = n + 1;
      end
      chk("stop done", 8'h00, v & 8'h04);
      rd(9'h0C1, v);
      chk("master off", 8'h00, v & 8'h20);
      chk("ack bit", {7'h00, hw}, {7'h00, slv_ack});
      @(negedge clk_in);
      chk("released", 8'h00, {4'h0, scl_oe_out, sda_oe_out});
      @(posedge clk_in);
      wr(9'h0C0, 8'h00);
      $display("master_read hw=%0d done", hw);
   end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      test_regs;
      master_read(1'b1);
      master_read(1'b0);
      close_out;
   end
   // Watchdog well beyond the several hundred cycles the tests need.
   initial
   begin
      #1000000;
      fail_count = fail_count + 1;
      close_out;
   end
endmodule
